// *** hdl/adc_conversion_read_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_read_sequencer #(
   parameter logic [6:0] SLAVE_ADDR = adc_seq_pkg::SLAVE_ADDR_DEFAULT
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic scl_out,
   output logic scl_oe_out,
   output logic conv_start_out,
   output logic conv_pos_out,
   output logic [1:0] conv_neg_out,
   output logic track_out,
   input wire logic conv_done_in,
   input wire logic [adc_seq_pkg::RES_BITS-1:0] conv_data_in
);
   import adc_seq_pkg::*;

   localparam logic [11:0] WDOG_LAST = 12'(STRETCH_CYC - 1);

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_q;
      logic sda_q;
      logic [2:0] tog_s;
      bus_state_t state;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rd;
      logic [1:0] scan;
      logic chan;
      logic sgl;
      logic clk_ext;
      logic byte_lo;
      logic [3:0] left;
      logic cur;
      logic busy;
      logic [11:0] wdog;
      logic [RES_BITS-1:0] last_res;
      logic sda_oe;
      logic scl_oe;
      logic start;
      logic pos;
      logic [1:0] neg;
      logic track;
      logic arm;
      logic mem_clr;
      logic mem_wr;
      logic [RES_BITS-1:0] mem_data;
      logic mem_adv;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic samp_evt;
   logic conv_end;
   logic [15:0] tx_word;

   result_mem_if mem_bus ();
   pacer_if pace_bus ();

   result_mem #(
      .DEPTH(MEM_DEPTH),
      .WIDTH(RES_BITS)
   ) u_mem (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .mem_port(mem_bus.mem)
   );

   link_conv_pacer #(
      .PERIOD(EXT_PERIOD_SCL)
   ) u_pacer (
      .scl_in(scl_in),
      .reset_n_in(reset_n_in),
      .pace(pace_bus.pacer)
   );

   assign scl_rise = s.scl_s[1] & ~s.scl_q;
   assign scl_fall = ~s.scl_s[1] & s.scl_q;
   assign start_c = s.scl_s[1] & s.scl_q & s.sda_q & ~s.sda_s[1];
   assign stop_c = s.scl_s[1] & s.scl_q & ~s.sda_q & s.sda_s[1];
   assign samp_evt = s.tog_s[1] ^ s.tog_s[2];
   // The watchdog forces completion so no single conversion can overrun the stretch limit
   assign conv_end = s.busy & (conv_done_in | (s.wdog == WDOG_LAST));
   assign tx_word = {PAD_VALUE,
      s.clk_ext ? s.last_res : mem_bus.rd_data};

   function automatic logic [3:0] bit_idx(input logic lo,
         input logic [2:0] n);
      return {~lo, ~n};
   endfunction : bit_idx

   function automatic logic [3:0] conv_count(input ctl_state_t x);
      logic [3:0] c;
      c = 4'h1;
      if (x.scan == SCAN_RANGE)
         c = (x.sgl && x.chan) ? 4'h2 : 4'h1;
      else if (x.scan == SCAN_REPEAT)
         c = REPEAT_COUNT;
      return c;
   endfunction : conv_count

   function automatic ctl_state_t launch(input ctl_state_t x);
      ctl_state_t y;
      y = x;
      y.start = 1'b1;
      y.busy = 1'b1;
      y.wdog = '0;
      y.track = 1'b0;
      y.pos = x.cur;
      if (x.sgl)
         y.neg = NEG_GND;
      else
         y.neg = x.cur ? NEG_ANALOG_INPUT_ZERO : NEG_ANALOG_INPUT_ONE;
      // Single-ended range scan steps up to the pick, other codes and differential range repeat the pick
      if (x.scan == SCAN_RANGE && x.sgl)
         y.cur = ~x.cur & x.chan;
      else
         y.cur = x.chan;
      return y;
   endfunction : launch

   always_comb begin
      next_s = s;
      next_s.scl_s = {s.scl_s[0], scl_in};
      next_s.sda_s = {s.sda_s[0], sda_in};
      next_s.scl_q = s.scl_s[1];
      next_s.sda_q = s.sda_s[1];
      next_s.tog_s = {s.tog_s[1:0], pace_bus.sample_tog};
      next_s.start = 1'b0;
      next_s.mem_clr = 1'b0;
      next_s.mem_wr = 1'b0;
      next_s.mem_adv = 1'b0;
      if (s.busy)
         next_s.wdog = s.wdog + 12'h001;
      if (conv_end) begin
         next_s.busy = 1'b0;
         next_s.last_res = conv_data_in;
         next_s.mem_wr = ~s.clk_ext;
         next_s.mem_data = conv_data_in;
         if (s.left != 4'h0)
            next_s.left = s.left - 4'h1;
      end
      // Bus-clock pacing: a sample event while armed and not busy starts the next conversion
      if (samp_evt && s.arm && !s.busy)
         next_s = launch(next_s);
      unique case (s.state)
         ST_IDLE: begin
         end
         ST_ADDR: begin
            if (scl_rise) begin
               next_s.shreg = {s.shreg[6:0], s.sda_s[1]};
               next_s.bitcnt = s.bitcnt + 4'h1;
               if (s.bitcnt == BYTE_BITS - 4'h1 && s.shreg[6:0] == SLAVE_ADDR
                     && s.sda_s[1]) begin
                  next_s.track = ~s.clk_ext;
                  next_s.arm = s.clk_ext;
               end
            end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
               if (s.shreg[7:1] == SLAVE_ADDR) begin
                  next_s.state = ST_AACK;
                  next_s.sda_oe = 1'b1;
                  next_s.rd = s.shreg[0];
               end else begin
                  next_s.state = ST_IDLE;
               end
            end
         end
         ST_AACK: begin
            if (scl_rise && s.rd && s.clk_ext)
               next_s.track = 1'b1;
            if (scl_fall) begin
               next_s.sda_oe = 1'b0;
               next_s.bitcnt = 4'h0;
               next_s.byte_lo = 1'b0;
               if (!s.rd) begin
                  next_s.state = ST_WBYTE;
               end else if (s.clk_ext) begin
                  next_s.state = ST_SEND;
                  next_s.sda_oe = ~tx_word[bit_idx(1'b0, 3'h0)];
                  // Start from input zero in a single-ended range scan, else from the pick, not from an older scan's input
                  next_s.cur = (s.scan == SCAN_RANGE && s.sgl) ?
                     1'b0 : s.chan;
               end else begin
                  // With the internal clock, every read address restarts a full scan
                  next_s.state = ST_CONV;
                  next_s.scl_oe = 1'b1;
                  next_s.mem_clr = 1'b1;
                  next_s.left = conv_count(s);
                  next_s.cur = (s.scan == SCAN_RANGE && s.sgl) ?
                     1'b0 : s.chan;
               end
            end
         end
         ST_CONV: begin
            if (!s.busy && !s.mem_clr) begin
               if (s.left == 4'h0) begin
                  next_s.scl_oe = 1'b0;
                  next_s.state = ST_SEND;
                  next_s.sda_oe = ~tx_word[bit_idx(1'b0, 3'h0)];
               end else begin
                  next_s = launch(next_s);
               end
            end
         end
         ST_SEND: begin
            if (scl_fall) begin
               if (s.bitcnt == BYTE_BITS - 4'h1) begin
                  next_s.state = ST_MACK;
                  next_s.sda_oe = 1'b0;
                  next_s.bitcnt = 4'h0;
               end else begin
                  next_s.bitcnt = s.bitcnt + 4'h1;
                  next_s.sda_oe = ~tx_word[bit_idx(s.byte_lo,
                     3'(s.bitcnt + 4'h1))];
               end
            end
         end
         ST_MACK: begin
            if (scl_rise && s.sda_s[1]) begin
               // Not-acknowledge ends the read and lets the pin float
               next_s.state = ST_IDLE;
               next_s.arm = 1'b0;
               next_s.track = 1'b0;
            end else if (scl_fall) begin
               next_s.state = ST_SEND;
               next_s.byte_lo = ~s.byte_lo;
               next_s.mem_adv = s.byte_lo & ~s.clk_ext;
               next_s.sda_oe = ~tx_word[bit_idx(~s.byte_lo, 3'h0)];
            end
         end
         ST_WBYTE: begin
            if (scl_rise) begin
               next_s.shreg = {s.shreg[6:0], s.sda_s[1]};
               next_s.bitcnt = s.bitcnt + 4'h1;
            end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
               next_s.state = ST_WACK;
               next_s.sda_oe = 1'b1;
               if (!s.shreg[CFG_REG_BIT]) begin
                  next_s.scan = s.shreg[SCAN_HI_BIT:SCAN_LO_BIT];
                  next_s.chan = s.shreg[CHAN_BIT];
                  next_s.sgl = s.shreg[SGL_BIT];
               end else begin
                  next_s.clk_ext = s.shreg[SETUP_CLK_BIT];
               end
            end
         end
         ST_WACK: begin
            if (scl_fall) begin
               next_s.state = ST_WBYTE;
               next_s.sda_oe = 1'b0;
               next_s.bitcnt = 4'h0;
            end
         end
      endcase
      if (start_c) begin
         next_s.state = ST_ADDR;
         next_s.bitcnt = 4'h0;
         next_s.sda_oe = 1'b0;
         next_s.arm = 1'b0;
         next_s.track = 1'b0;
      end else if (stop_c) begin
         next_s.state = ST_IDLE;
         next_s.sda_oe = 1'b0;
         next_s.arm = 1'b0;
         next_s.track = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s <= '0;
         s.scan <= SCAN_RST;
         s.chan <= CHAN_RST;
         s.sgl <= SGL_RST;
         s.clk_ext <= CLK_EXT_RST;
      end else begin
         s <= next_s;
      end
   end

   assign mem_bus.clear = s.mem_clr;
   assign mem_bus.wr = s.mem_wr;
   assign mem_bus.wr_data = s.mem_data;
   assign mem_bus.adv = s.mem_adv;
   assign pace_bus.arm = s.arm;

   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign sda_oe_out = s.sda_oe;
   assign scl_oe_out = s.scl_oe;
   assign conv_start_out = s.start;
   assign conv_pos_out = s.pos;
   assign conv_neg_out = s.neg;
   assign track_out = s.track;

   default clocking dcb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);

   a_cfg_fields: assert property ($past(s.state) == ST_WBYTE
      && s.state == ST_WACK && !s.shreg[CFG_REG_BIT]
      |-> s.chan == s.shreg[CHAN_BIT] && s.sgl == s.shreg[SGL_BIT])
      else $error("configuration byte not decoded");
   a_cfg_scan: assert property ($past(s.state) == ST_WBYTE
      && s.state == ST_WACK && !s.shreg[CFG_REG_BIT]
      |-> s.scan == s.shreg[SCAN_HI_BIT:SCAN_LO_BIT])
      else $error("scan bits not decoded");
   a_setup_clock: assert property ($past(s.state) == ST_WBYTE
      && s.state == ST_WACK && s.shreg[CFG_REG_BIT]
      |-> s.clk_ext == s.shreg[SETUP_CLK_BIT])
      else $error("clock source not decoded");
   a_mux_single: assert property (conv_start_out && s.sgl
      |-> conv_neg_out == NEG_GND)
      else $error("single-ended input not against ground");
   a_mux_diff: assert property (conv_start_out && !s.sgl
      |-> conv_neg_out == (conv_pos_out ? NEG_ANALOG_INPUT_ZERO : NEG_ANALOG_INPUT_ONE))
      else $error("differential polarity wrong");
   a_addr_ack: assert property ($past(s.state) == ST_ADDR
      && s.state == ST_AACK |-> sda_oe_out && s.shreg[7:1] == SLAVE_ADDR)
      else $error("address acknowledge wrong");
   a_pad_high: assert property (s.state == ST_SEND && !s.byte_lo
      && s.bitcnt < PAD_COUNT |-> !sda_oe_out)
      else $error("pad bit driven low");
   a_nack_end: assert property (s.state == ST_MACK && scl_rise
      && s.sda_s[1] |=> s.state == ST_IDLE && !sda_oe_out && !s.arm)
      else $error("not-acknowledge did not end the read");
   a_stretch_hold: assert property (s.state == ST_CONV
      |-> scl_oe_out ##1 (scl_oe_out || s.state == ST_SEND))
      else $error("clock released during conversion");
   a_release_done: assert property ($fell(s.scl_oe) && !$past(start_c)
      |-> $past(s.left) == 4'h0 && !$past(s.busy))
      else $error("clock released before results stored");
   a_stretch_bound: assert property (s.busy |-> s.wdog <= WDOG_LAST)
      else $error("stretch exceeds limit");
   a_ext_pace: assert property (samp_evt && s.arm && !s.busy
      |=> conv_start_out && !scl_oe_out)
      else $error("bus-clock sample not started");

   c_int_read: cover property ($fell(s.scl_oe) && s.state == ST_SEND);
   c_nack: cover property (s.state == ST_MACK && scl_rise && s.sda_s[1]);
   c_ext_sample: cover property (samp_evt && s.arm);
   c_wdog_end: cover property (conv_end && s.wdog == WDOG_LAST);
endmodule : adc_conversion_read_sequencer
`default_nettype wire

// *** hdl/link_conv_pacer.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_conv_pacer #(
   parameter int PERIOD = 18
) (
   input wire logic scl_in,
   input wire logic reset_n_in,
   pacer_if.pacer pace
);
   localparam int CW = $clog2(PERIOD);

   if (PERIOD < 2) begin : g_bad
      $error("link_conv_pacer: period too short");
   end

   typedef struct packed {
      logic [1:0] arm_s;
      logic [CW-1:0] cnt;
      logic tog;
   } pace_state_t;
   pace_state_t p;
   pace_state_t next_p;

   // Runs on the bus clock itself, which pauses between frames; the arm
   // level takes two bus clocks to pass, which sets the sampling moment.
   always_comb begin
      next_p = p;
      next_p.arm_s = {p.arm_s[0], pace.arm};
      if (!p.arm_s[1]) begin
         next_p.cnt = '0;
      end else begin
         if (p.cnt == '0)
            next_p.tog = ~p.tog;
         next_p.cnt = (p.cnt == CW'(PERIOD - 1)) ? '0 : p.cnt + 1'b1;
      end
   end

   always_ff @(posedge scl_in or negedge reset_n_in) begin
      if (!reset_n_in)
         p <= '0;
      else
         p <= next_p;
   end

   assign pace.sample_tog = p.tog;

   a_first_sample: assert property (@(posedge scl_in) disable iff (!reset_n_in)
      $rose(p.arm_s[1]) |=> p.tog != $past(p.tog))
      else $error("no sample after arming");
endmodule : link_conv_pacer
`default_nettype wire

// *** hdl/result_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module result_mem #(
   parameter int DEPTH = 2,
   parameter int WIDTH = 12
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   result_mem_if.mem mem_port
);
   import adc_seq_pkg::*;
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || WIDTH != RES_BITS) begin : g_bad
      $error("result_mem: unsupported depth or width");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] ent;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } mem_state_t;
   mem_state_t m;
   mem_state_t next_m;

   always_comb begin
      next_m = m;
      if (mem_port.clear) begin
         next_m.wp = '0;
         next_m.rp = '0;
         next_m.cnt = '0;
      end else if (mem_port.wr) begin
         next_m.ent[m.wp] = mem_port.wr_data;
         next_m.wp = (m.wp == PW'(DEPTH - 1)) ? '0 : m.wp + 1'b1;
         if (m.cnt != (PW + 1)'(DEPTH))
            next_m.cnt = m.cnt + 1'b1;
      end
      if (mem_port.adv && !mem_port.clear) begin
         // Wrap to the first entry after the last one written
         if ({1'b0, m.rp} + 1'b1 >= m.cnt)
            next_m.rp = '0;
         else
            next_m.rp = m.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in)
         m <= '0;
      else
         m <= next_m;
   end

   assign mem_port.rd_data = m.ent[m.rp];

   a_rd_wrap: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      mem_port.adv && !mem_port.clear && ({1'b0, m.rp} + 1'b1 >= m.cnt)
      |=> m.rp == '0) else $error("read pointer did not wrap");
   a_wr_order: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      mem_port.wr && !mem_port.clear
      |=> m.ent[$past(m.wp)] == $past(mem_port.wr_data))
      else $error("result not stored in order");
endmodule : result_mem
`default_nettype wire

// *** pkg/adc_seq_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface result_mem_if;
   logic clear;
   logic wr;
   logic [adc_seq_pkg::RES_BITS-1:0] wr_data;
   logic adv;
   logic [adc_seq_pkg::RES_BITS-1:0] rd_data;
   modport mem (input clear, input wr, input wr_data, input adv,
      output rd_data);
   modport user (output clear, output wr, output wr_data, output adv,
      input rd_data);
endinterface : result_mem_if

interface pacer_if;
   logic arm;
   logic sample_tog;
   modport pacer (input arm, output sample_tog);
   modport ctrl (output arm, input sample_tog);
endinterface : pacer_if
`default_nettype wire

// *** pkg/adc_seq_pkg.sv ***
`default_nettype none
package adc_seq_pkg;
   localparam int RES_BITS = 12;
   localparam logic [3:0] PAD_VALUE = 4'hF;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] PAD_COUNT = 4'h4;
   localparam int CFG_REG_BIT = 7;
   localparam int SCAN_HI_BIT = 6;
   localparam int SCAN_LO_BIT = 5;
   localparam int CHAN_BIT = 1;
   localparam int SGL_BIT = 0;
   localparam int SETUP_CLK_BIT = 3;
   localparam logic [1:0] SCAN_RST = 2'h0;
   localparam logic CHAN_RST = 1'h0;
   localparam logic SGL_RST = 1'h1;
   localparam logic CLK_EXT_RST = 1'h0;
   localparam logic [1:0] SCAN_RANGE = 2'h0;
   localparam logic [1:0] SCAN_REPEAT = 2'h1;
   localparam logic [3:0] REPEAT_COUNT = 4'h8;
   localparam logic [1:0] NEG_GND = 2'h0;
   localparam logic [1:0] NEG_ANALOG_INPUT_ZERO = 2'h1;
   localparam logic [1:0] NEG_ANALOG_INPUT_ONE = 2'h2;
   localparam int MEM_DEPTH = 2;
   localparam int EXT_PERIOD_SCL = 18;
   localparam real STRETCH_US = 8.3;
   localparam real SYS_MHZ = 250.0;
   localparam int STRETCH_CYC = int'($floor(STRETCH_US * SYS_MHZ));
   // Arbitrary bus address, not tied to any real part
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_CONV = 3'h2,
      ST_SEND = 3'h6,
      ST_MACK = 3'h7,
      ST_WBYTE = 3'h5,
      ST_WACK = 3'h4
   } bus_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

// *** tb/adc_conversion_read_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_read_sequencer_bench;
   import adc_seq_pkg::*;
   logic clk_sys_in, reset_n_in, sda_drv, scl_drv, stuck;
   logic sda_wire, scl_wire, conv_done_in, track;
   logic sda_oe_out, scl_oe_out, conv_start_out, conv_pos_out;
   logic [1:0] conv_neg_out;
   logic [11:0] conv_data_in;
   logic [3:0] n_conv;
   int num_errors, checks, busy;
   // Open-drain wires with pull-ups
   assign sda_wire = sda_drv & ~sda_oe_out;
   assign scl_wire = scl_drv & ~scl_oe_out;
   always #2 clk_sys_in = ~clk_sys_in;
   adc_conversion_read_sequencer uut (.clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in), .scl_in(scl_wire), .sda_in(sda_wire),
      .sda_out(), .sda_oe_out(sda_oe_out), .scl_out(),
      .scl_oe_out(scl_oe_out), .conv_start_out(conv_start_out),
      .conv_pos_out(conv_pos_out), .conv_neg_out(conv_neg_out),
      .track_out(track), .conv_done_in(conv_done_in),
      .conv_data_in(conv_data_in));
   bus_master_model master (.sda_in(sda_wire), .scl_in(scl_wire),
      .sda_out(sda_drv), .scl_out(scl_drv), .stuck_out(stuck));
   // Converter: result encodes order and mux choice for checking
   always @(posedge clk_sys_in) begin
      #1;
      conv_done_in = (busy == 1);
      if (busy > 0) busy--;
      if (conv_start_out === 1'b1) begin
         n_conv++;
         conv_data_in = {n_conv, 5'h00, conv_pos_out, conv_neg_out};
         busy = 20;
      end
   end
   task automatic stop_test();
      $display("Errors %0d, checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp || stuck === 1'b1) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
      if (stuck === 1'b1) stop_test();
   endtask : check
   task automatic wr_cfg(input logic [7:0] cfg);
      logic [7:0] rx;
      logic a;
      master.go_start();
      master.xfer({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a);
      check({11'h000, a}, 12'h000);
      master.xfer(cfg, 1'b1, rx, a);
      check({11'h000, a}, 12'h000);
      master.go_stop();
   endtask : wr_cfg
   task automatic rd_open(input logic [6:0] addr, input logic exp_ack);
      logic [7:0] rx;
      logic a;
      master.go_start();
      master.xfer({addr, 1'b1}, 1'b1, rx, a);
      check({11'h000, a}, {11'h000, exp_ack});
   endtask : rd_open
   task automatic rd_word(input logic [11:0] exp, input logic nack);
      logic [7:0] b0, b1;
      logic a;
      master.xfer(8'hFF, 1'b0, b0, a);
      check({4'h0, b0}, {4'h0, PAD_VALUE, exp[11:8]});
      master.xfer(8'hFF, nack, b1, a);
      check({4'h0, b1}, {4'h0, exp[7:0]});
   endtask : rd_word
   task automatic rd_close();
      #200;
      check({11'h000, sda_oe_out}, 12'h000);
      master.go_stop();
   endtask : rd_close
   task automatic scen_defaults();
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      rd_word(12'h100, 1'b0);
      rd_word(12'h100, 1'b1);
      rd_close();
   endtask : scen_defaults
   task automatic scen_diff();
      wr_cfg(8'h7E);
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      rd_word(12'h105, 1'b1);
      rd_close();
      wr_cfg(8'h60);
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      rd_word(12'h102, 1'b1);
      rd_close();
   endtask : scen_diff
   task automatic scen_scan_up();
      wr_cfg(8'h03);
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      rd_word(12'h100, 1'b0);
      rd_word(12'h204, 1'b0);
      rd_word(12'h100, 1'b1);
      rd_close();
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      rd_word(12'h300, 1'b0);
      rd_word(12'h404, 1'b1);
      rd_close();
   endtask : scen_scan_up
   task automatic scen_repeat();
      wr_cfg(8'h23);
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      rd_word(12'h704, 1'b0);
      rd_word(12'h804, 1'b1);
      rd_close();
   endtask : scen_repeat
   task automatic scen_refusals();
      logic [7:0] rx;
      logic a;
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT ^ 7'h01, 1'b1);
      master.go_stop();
      check({8'h00, n_conv}, 12'h000);
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      master.xfer(8'hFF, 1'b1, rx, a);
      rd_close();
   endtask : scen_refusals
   task automatic scen_ext_clock();
      wr_cfg(8'h88);
      wr_cfg(8'h61);
      n_conv = 4'h0;
      rd_open(SLAVE_ADDR_DEFAULT, 1'b0);
      check({11'h000, track}, 12'h001);
      rd_word(12'h100, 1'b0);
      rd_word(12'h200, 1'b1);
      rd_close();
   endtask : scen_ext_clock
   initial begin
      clk_sys_in = 1'b0;
      reset_n_in = 1'b0;
      conv_done_in = 1'b0;
      conv_data_in = 12'h000;
      n_conv = 4'h0;
      busy = 0;
      num_errors = 0;
      checks = 0;
      repeat (4) @(posedge clk_sys_in);
      #1;
      reset_n_in = 1'b1;
      #100;
      scen_defaults();
      scen_diff();
      scen_scan_up();
      scen_repeat();
      scen_refusals();
      scen_ext_clock();
      stop_test();
   end
endmodule : adc_conversion_read_sequencer_bench
`default_nettype wire

// *** tb/bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
   parameter int HALF = 60
) (
   input wire logic sda_in,
   input wire logic scl_in,
   output logic sda_out,
   output logic scl_out,
   output logic stuck_out
);
   initial begin
      sda_out = 1'b1;
      scl_out = 1'b1;
      stuck_out = 1'b0;
   end
   // The slave may stretch the low phase, so the wait for high is bounded
   task automatic clk_bit(input logic b, output logic r);
      int n;
      sda_out = b;
      #HALF;
      scl_out = 1'b1;
      n = 0;
      while (scl_in !== 1'b1 && n < 20000) begin
         #4;
         n++;
      end
      if (n >= 20000) stuck_out = 1'b1;
      #HALF;
      r = sda_in;
      scl_out = 1'b0;
      // Data moves only well after the fall seen by the slave
      #8;
   endtask : clk_bit
   task automatic xfer(input logic [7:0] tx, input logic ack_tx,
         output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], rx[i]);
      end
      clk_bit(ack_tx, ack_rx);
   endtask : xfer
   task automatic go_start();
      sda_out = 1'b1;
      #HALF;
      scl_out = 1'b1;
      #HALF;
      sda_out = 1'b0;
      #HALF;
      scl_out = 1'b0;
      #8;
   endtask : go_start
   task automatic go_stop();
      sda_out = 1'b0;
      #HALF;
      scl_out = 1'b1;
      #HALF;
      sda_out = 1'b1;
      #HALF;
   endtask : go_stop
endmodule : bus_master_model
`default_nettype wire
